//--- hdl/ssrl_top.sv
// Serial programming front end with control latches and field decode
`timescale 1ns/1ps
module ssrl_top (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial link pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic latch_strobe,
  // Chip enable pin
  input wire logic chip_enable,
  // Divider word fields
  output logic [10:0] main_divider_value,
  output logic [21:0] fraction_numerator,
  output logic [21:0] fraction_denominator,
  output logic [6:0] prescaler_cycle_count,
  output logic [1:0] divider_field_b,
  output logic [1:0] divider_field_a,
  output logic [11:0] divider_total,
  output logic divider_in_range,
  // Register one and two fields
  output logic main_power_down,
  output logic prescaler_select,
  output logic [5:0] reference_divider,
  output logic aux_power_down,
  output logic [18:0] aux_divider,
  // Register three fields
  output logic [3:0] access_enables,
  output logic [3:0] main_pump_gain,
  output logic [11:0] aux_ref_divider,
  // Register four, six and seven fields
  output logic auto_power_up,
  output logic [1:0] modulator_order,
  output logic [1:0] slip_reduction_factor,
  output logic [3:0] fastlock_pump_gain,
  output logic [13:0] fastlock_timeout_count,
  output logic [23:0] misc_test_word,
  // Derived control
  output logic main_powered_down,
  output logic counters_reset
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sclk_d_r;
  logic le_d_r;
  logic ce_s1_r;
  logic ce_s2_r;

  // Two flops on every pin except rst_n before any logic looks at it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      ce_s1_r <= 1'h0;
      ce_s2_r <= 1'h0;
    end else begin
      sync1_r <= {ser_clk, ser_data, latch_strobe};
      sync2_r <= sync1_r;
      ce_s1_r <= chip_enable;
      ce_s2_r <= ce_s1_r;
    end
  end

  wire sclk_s = sync2_r[2];
  wire sdat_s = sync2_r[1];
  wire le_s = sync2_r[0];

  // Edge detect history
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'h0;
      le_d_r <= 1'h0;
    end else begin
      sclk_d_r <= sclk_s;
      le_d_r <= le_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire le_rise = le_s & ~le_d_r;

  // ------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------
  logic [23:0] shift_r;
  logic [4:0] bitcnt_r;

  // Data is sampled on the serial clock rising edge; the data line has
  // travelled the same two-flop path, so it stays aligned with the clock.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= ssrl_pkg::REG_RESET;
    end else if (sclk_rise && !le_s) begin
      shift_r <= {shift_r[22:0], sdat_s};
    end
  end

  // Counts bits since the last transfer, saturating at a full word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt_r <= 5'h00;
    end else if (le_rise) begin
      bitcnt_r <= 5'h00;
    end else if (sclk_rise && !le_s &&
                 bitcnt_r != ssrl_pkg::BITCNT_FULL) begin
      bitcnt_r <= bitcnt_r + 5'h01;
    end
  end

  wire word_full = (bitcnt_r == ssrl_pkg::BITCNT_FULL);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic [7:0] sel;
  wire [3:0] addr_code_bits = shift_r[3:0];

  // One-hot latch select; unmatched even codes cannot occur past bit 0
  always_comb begin
    sel = 8'h00;
    if (!addr_code_bits[0]) begin
      sel[ssrl_pkg::IDX_DIV] = 1'b1;
    end else begin
      unique case (addr_code_bits)
        ssrl_pkg::ADDR_REG1: sel[ssrl_pkg::IDX_REF] = 1'b1;
        ssrl_pkg::ADDR_REG2: sel[ssrl_pkg::IDX_AUX] = 1'b1;
        ssrl_pkg::ADDR_REG3: sel[ssrl_pkg::IDX_PUMP] = 1'b1;
        ssrl_pkg::ADDR_REG4: sel[ssrl_pkg::IDX_MOD] = 1'b1;
        ssrl_pkg::ADDR_REG5: sel[ssrl_pkg::IDX_FRAC] = 1'b1;
        ssrl_pkg::ADDR_REG6: sel[ssrl_pkg::IDX_FAST] = 1'b1;
        ssrl_pkg::ADDR_REG7: sel[ssrl_pkg::IDX_MISC] = 1'b1;
        default: sel = 8'h00;
      endcase
    end
  end

  wire load_en = le_rise && word_full;

  // ------------------------------------------------------------
  // Control latches, write only
  // ------------------------------------------------------------
  logic [23:0] regs_r [ssrl_pkg::NUM_REGS];

  // Only the addressed latch changes; all others keep their value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ssrl_pkg::NUM_REGS; i++) begin
        regs_r[i] <= ssrl_pkg::REG_RESET;
      end
    end else if (load_en) begin
      for (int i = 0; i < ssrl_pkg::NUM_REGS; i++) begin
        if (sel[i]) begin
          regs_r[i] <= shift_r;
        end
      end
    end
  end

  // Counter reset pulse on a divider-word write, one cycle wide
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counters_reset <= 1'b0;
    end else begin
      counters_reset <= load_en && sel[ssrl_pkg::IDX_DIV];
    end
  end

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  wire [23:0] r0 = regs_r[ssrl_pkg::IDX_DIV];
  wire [23:0] r1 = regs_r[ssrl_pkg::IDX_REF];
  wire [23:0] r2 = regs_r[ssrl_pkg::IDX_AUX];
  wire [23:0] r3 = regs_r[ssrl_pkg::IDX_PUMP];
  wire [23:0] r4 = regs_r[ssrl_pkg::IDX_MOD];
  wire [23:0] r5 = regs_r[ssrl_pkg::IDX_FRAC];
  wire [23:0] r6 = regs_r[ssrl_pkg::IDX_FAST];

  // Divider word and fraction, low parts in register zero and one
  assign main_divider_value = r0[ssrl_pkg::DIV_HI:ssrl_pkg::DIV_LO];
  assign fraction_numerator = {r5[ssrl_pkg::UFN_HI:ssrl_pkg::UFN_LO],
                               r0[ssrl_pkg::FN_HI:ssrl_pkg::FN_LO]};
  assign fraction_denominator = {r5[ssrl_pkg::UFD_HI:ssrl_pkg::UFD_LO],
                                 r1[ssrl_pkg::FD_HI:ssrl_pkg::FD_LO]};

  // Divider split into prescaler cycle count and the two small fields
  assign prescaler_cycle_count =
    main_divider_value[ssrl_pkg::CYC_HI:ssrl_pkg::CYC_LO];
  assign divider_field_b = main_divider_value[ssrl_pkg::FB_HI:ssrl_pkg::FB_LO];
  assign divider_field_a = main_divider_value[ssrl_pkg::FA_HI:ssrl_pkg::FA_LO];

  // Register one and two
  assign main_power_down = r1[ssrl_pkg::PD_BIT];
  assign prescaler_select = r1[ssrl_pkg::PSEL_BIT];
  assign reference_divider = r1[ssrl_pkg::REFD_HI:ssrl_pkg::REFD_LO];
  assign aux_power_down = r2[ssrl_pkg::PD_BIT];
  assign aux_divider = r2[ssrl_pkg::AUXN_HI:ssrl_pkg::AUXN_LO];

  // Register three
  assign access_enables = r3[ssrl_pkg::ACC_HI:ssrl_pkg::ACC_LO];
  assign main_pump_gain = r3[ssrl_pkg::CPG_HI:ssrl_pkg::CPG_LO];
  assign aux_ref_divider = r3[ssrl_pkg::AUXR_HI:ssrl_pkg::AUXR_LO];

  // Register four, six and seven
  assign auto_power_up = r4[ssrl_pkg::AUTO_POWER_UP_BIT];
  assign modulator_order = r4[ssrl_pkg::FM_HI:ssrl_pkg::FM_LO];
  assign slip_reduction_factor = r6[ssrl_pkg::CSR_HI:ssrl_pkg::CSR_LO];
  assign fastlock_pump_gain = r6[ssrl_pkg::CPF_HI:ssrl_pkg::CPF_LO];
  assign fastlock_timeout_count = r6[ssrl_pkg::TOC_HI:ssrl_pkg::TOC_LO];
  assign misc_test_word = regs_r[ssrl_pkg::IDX_MISC];

  // ------------------------------------------------------------
  // Division total and range check
  // ------------------------------------------------------------
  logic [4:0] presc_size;
  logic [11:0] prod;

  // Prescaler size times cycle count plus four B plus A
  always_comb begin
    presc_size = prescaler_select ? ssrl_pkg::PRESC_LARGE
                                  : ssrl_pkg::PRESC_SMALL;
    prod = 12'(presc_size * prescaler_cycle_count);
    divider_total = prod + {8'h00, divider_field_b, 2'b00}
                  + {10'h000, divider_field_a};
  end

  // Flags a division total inside the range for the chosen prescaler;
  // the raw field is not the division, so the total is what is judged.
  // Finer order-dependent limits are left to the host
  always_comb begin
    if (prescaler_select) begin
      divider_in_range =
        divider_total >= {1'b0, ssrl_pkg::NMIN_LARGE} &&
        divider_total <= {1'b0, ssrl_pkg::NMAX_LARGE};
    end else begin
      divider_in_range =
        divider_total >= {1'b0, ssrl_pkg::NMIN_SMALL} &&
        divider_total <= {1'b0, ssrl_pkg::NMAX_SMALL};
    end
  end

  // ------------------------------------------------------------
  // Power-down precedence
  // ------------------------------------------------------------
  // Chip enable low wins, then auto power-up, then the stored bit
  assign main_powered_down = !ce_s2_r ? 1'b1 :
                             auto_power_up ? 1'b0 : main_power_down;

endmodule

//--- shared/ssrl_pkg.sv
// Constants for the synthesizer serial register load block
package ssrl_pkg;
  localparam int WORD_BITS = 24;
  localparam int ADDR_BITS = 4;
  localparam int NUM_REGS = 8;
  localparam logic [2:0] CNT_W = 3'h0;
  // Address codes, low to high, for registers one to seven
  localparam logic [3:0] ADDR_REG1 = 4'h3;
  localparam logic [3:0] ADDR_REG2 = 4'h5;
  localparam logic [3:0] ADDR_REG3 = 4'h7;
  localparam logic [3:0] ADDR_REG4 = 4'h9;
  localparam logic [3:0] ADDR_REG5 = 4'hB;
  localparam logic [3:0] ADDR_REG6 = 4'hD;
  localparam logic [3:0] ADDR_REG7 = 4'hF;
  // Register indices
  localparam int IDX_DIV = 0;
  localparam int IDX_REF = 1;
  localparam int IDX_AUX = 2;
  localparam int IDX_PUMP = 3;
  localparam int IDX_MOD = 4;
  localparam int IDX_FRAC = 5;
  localparam int IDX_FAST = 6;
  localparam int IDX_MISC = 7;
  // Field positions
  localparam int DIV_HI = 23;
  localparam int DIV_LO = 13;
  localparam int FN_HI = 12;
  localparam int FN_LO = 1;
  localparam int PD_BIT = 23;
  localparam int PSEL_BIT = 22;
  localparam int REFD_HI = 21;
  localparam int REFD_LO = 16;
  localparam int FD_HI = 15;
  localparam int FD_LO = 4;
  localparam int AUXN_HI = 22;
  localparam int AUXN_LO = 4;
  localparam int ACC_HI = 23;
  localparam int ACC_LO = 20;
  localparam int CPG_HI = 19;
  localparam int CPG_LO = 16;
  localparam int AUXR_HI = 15;
  localparam int AUXR_LO = 4;
  localparam int UFD_HI = 23;
  localparam int UFD_LO = 14;
  localparam int UFN_HI = 13;
  localparam int UFN_LO = 4;
  localparam int CSR_HI = 23;
  localparam int CSR_LO = 22;
  localparam int CPF_HI = 21;
  localparam int CPF_LO = 18;
  localparam int TOC_HI = 17;
  localparam int TOC_LO = 4;
  localparam int AUTO_POWER_UP_BIT = 23;
  localparam int FM_HI = 19;
  localparam int FM_LO = 18;
  // Divider word sub-fields inside the 11-bit value
  localparam int CYC_HI = 10;
  localparam int CYC_LO = 4;
  localparam int FB_HI = 3;
  localparam int FB_LO = 2;
  localparam int FA_HI = 1;
  localparam int FA_LO = 0;
  localparam logic [23:0] REG_RESET = 24'h000000;
  localparam logic [4:0] BITCNT_FULL = 5'h18;
  // Prescaler base sizes for the small and large quadruple-modulus parts
  localparam logic [4:0] PRESC_SMALL = 5'h08;
  localparam logic [4:0] PRESC_LARGE = 5'h10;
  // Legal divider ranges
  localparam logic [10:0] NMIN_SMALL = 11'h019;
  localparam logic [10:0] NMAX_SMALL = 11'h3FF;
  localparam logic [10:0] NMIN_LARGE = 11'h037;
  localparam logic [10:0] NMAX_LARGE = 11'h7F7;
endpackage

//--- testbench/ssrl_props.sv
// Concurrent checks on the serial register load ports
`timescale 1ns/1ps
module ssrl_props (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins
  input wire logic latch_strobe,
  input wire logic chip_enable,
  // Observed fields
  input wire logic [10:0] main_divider_value,
  input wire logic [11:0] divider_total,
  input wire logic divider_in_range,
  input wire logic prescaler_select,
  input wire logic [5:0] reference_divider,
  input wire logic [18:0] aux_divider,
  input wire logic main_power_down,
  input wire logic auto_power_up,
  input wire logic main_powered_down,
  input wire logic counters_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Total from the split fields of the divider word
  total_ok_a: assert property (
    divider_total == (prescaler_select ? 12'h010 : 12'h008)
      * {5'h00, main_divider_value[10:4]}
      + {8'h00, main_divider_value[3:2], 2'h0}
      + {10'h000, main_divider_value[1:0]}) else $error("bad total");
  range_ok_a: assert property (
    divider_in_range == (prescaler_select
      ? (divider_total >= 12'h037 && divider_total <= 12'h7F7)
      : (divider_total >= 12'h019 && divider_total <= 12'h3FF)))
    else $error("bad range flag");
  // Pin passes two sync flops, so allow a few edges
  pwr_ce_a: assert property (
    !chip_enable [*4] |-> main_powered_down) else $error("ce ignored");
  pwr_prec_a: assert property (
    chip_enable [*4] |->
      main_powered_down == (!auto_power_up && main_power_down))
    else $error("bad power precedence");
  // Restart pulse is one cycle wide and rides on the strobe
  pulse_one_a: assert property (
    counters_reset |-> latch_strobe ##1 !counters_reset)
    else $error("bad restart pulse");
  div_pulse_a: assert property (
    $changed(main_divider_value) |-> counters_reset)
    else $error("no restart pulse");
  other_keep_a: assert property (
    counters_reset |-> $stable(reference_divider) && $stable(aux_divider))
    else $error("other latch moved");
  // Without a recent strobe edge the divider, register one and register two fields may not move
  hold_low_a: assert property (
    !latch_strobe [*6] |-> $stable(main_divider_value)
      && $stable(reference_divider) && $stable(aux_divider))
    else $error("latch moved unstrobed");
endmodule

//--- testbench/ssrl_host_model.sv
// Host controller model for the three-wire programming link
`timescale 1ns/1ps
module ssrl_host_model (
  // System
  input wire logic clk_sys,
  // Serial link
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  // Link idles with the clock parked low
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // Low n bits of w, first bit on top, then the strobe
  task automatic send(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk_sys);
      ser_clk = 1'b0;
      ser_data = w[i];
      repeat (4) @(negedge clk_sys);
      ser_clk = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
    ser_clk = 1'b0;
    // Hold time is over, so the line no longer shows the bit
    ser_data = ~ser_data;
    repeat (2) @(negedge clk_sys);
    latch_strobe = 1'b1;
    repeat (8) @(negedge clk_sys);
    latch_strobe = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

//--- testbench/tb_synth_serial_register_load.sv
// Self-checking bench for the serial register load block
`timescale 1ns/1ps
module tb_synth_serial_register_load;
  logic clk_sys, rst_n, chip_enable, ser_clk, ser_data, latch_strobe;
  logic [10:0] main_divider_value;
  logic [21:0] fraction_numerator, fraction_denominator;
  logic [18:0] aux_divider;
  logic [13:0] fastlock_timeout_count;
  logic [11:0] aux_ref_divider;
  logic [5:0] reference_divider;
  logic [3:0] access_enables, main_pump_gain, fastlock_pump_gain;
  logic [1:0] modulator_order, slip_reduction_factor;
  logic [23:0] misc_test_word;
  logic divider_in_range, main_power_down, prescaler_select, aux_power_down;
  logic auto_power_up, main_powered_down, counters_reset;
  int fail_count = 0;
  int comparisons = 0;
  int pulses = 0;
  int cycles = 0;
  logic [23:0] tbl [8] = '{24'hF0F0FE, 24'hA56783, 24'hC3A5F5, 24'h5AC3B7,
    24'hFFFFF9, 24'h3C96AB, 24'h9E1E4D, 24'h12345F};
  ssrl_host_model hm (.clk_sys(clk_sys), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_strobe(latch_strobe));
  ssrl_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .ser_clk(ser_clk),
    .ser_data(ser_data), .latch_strobe(latch_strobe),
    .chip_enable(chip_enable), .main_divider_value(main_divider_value),
    .fraction_numerator(fraction_numerator),
    .fraction_denominator(fraction_denominator),
    .prescaler_cycle_count(), .divider_field_b(), .divider_field_a(),
    .divider_total(), .divider_in_range(divider_in_range),
    .main_power_down(main_power_down), .prescaler_select(prescaler_select),
    .reference_divider(reference_divider), .aux_power_down(aux_power_down),
    .aux_divider(aux_divider), .access_enables(access_enables),
    .main_pump_gain(main_pump_gain), .aux_ref_divider(aux_ref_divider),
    .auto_power_up(auto_power_up), .modulator_order(modulator_order),
    .slip_reduction_factor(slip_reduction_factor),
    .fastlock_pump_gain(fastlock_pump_gain),
    .fastlock_timeout_count(fastlock_timeout_count),
    .misc_test_word(misc_test_word), .main_powered_down(main_powered_down),
    .counters_reset(counters_reset));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Count restart pulses and cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (counters_reset === 1'b1)
      pulses <= pulses + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Rebuild each latch image from the field outputs
  function automatic logic [23:0] view(input int k);
    case (k)
      0: view = {main_divider_value, fraction_numerator[11:0], 1'b0};
      1: view = {main_power_down, prescaler_select, reference_divider,
        fraction_denominator[11:0], 4'h3};
      2: view = {aux_power_down, aux_divider, 4'h5};
      3: view = {access_enables, main_pump_gain, aux_ref_divider, 4'h7};
      4: view = {auto_power_up, 3'h0, modulator_order, 14'h0000, 4'h9};
      5: view = {fraction_denominator[21:12], fraction_numerator[21:12],
        4'hB};
      6: view = {slip_reduction_factor, fastlock_pump_gain,
        fastlock_timeout_count, 4'hD};
      default: view = misc_test_word;
    endcase
  endfunction
  task automatic t_reset();
    for (int k = 0; k < 8; k++)
      chk(view(k) & 24'hFFFFF0, 24'h000000);
    chk({23'h000000, main_powered_down}, 24'h000000);
  endtask
  // Bring-up set: fixed register four, divider last, register seven skipped
  task automatic t_quick();
    hm.send(32'h0020C709, 24);
    hm.send({8'h00, 11'h031, 12'h001, 1'b0}, 24);
    chk(view(4), 24'h000009);
    chk(misc_test_word, tbl[7]);
  endtask
  // Each latch by its code, divider word last with odd upper code bits
  task automatic t_regs();
    int p;
    for (int k = 1; k < 8; k++) begin
      hm.send({8'h00, tbl[k]}, 24);
      chk(view(k), k == 4 ? 24'h8C0009 : tbl[k]);
    end
    p = pulses;
    hm.send({8'h00, tbl[0]}, 24);
    chk(view(0), tbl[0]);
    for (int k = 1; k < 8; k++)
      chk(view(k), k == 4 ? 24'h8C0009 : tbl[k]);
    chk(24'(pulses - p), 24'h000001);
  endtask
  // Window edges 24, 25, 1023, 1024; top bit is the expected flag
  task automatic t_range();
    logic [11:0] cs [4] = '{12'h030, 12'h831, 12'hFF7, 12'h7F8};
    for (int i = 0; i < 4; i++) begin
      hm.send({8'h00, cs[i][10:0], 12'h5A5, 1'b0}, 24);
      chk({23'h000000, divider_in_range}, {23'h000000, cs[i][11]});
    end
  endtask
  // Short word is dropped, long word keeps its last 24 bits
  task automatic t_refuse();
    hm.send(32'h005A5A53, 23);
    chk(view(1), tbl[1]);
    hm.send(32'h035A5A53, 26);
    chk(view(1), 24'h5A5A53);
  endtask
  // Bits: enable, auto power-up, power-down bit, expected state
  task automatic t_power();
    logic [3:0] pc [4] = '{4'h5, 4'hE, 4'hB, 4'h8};
    for (int i = 0; i < 4; i++) begin
      hm.send({8'h00, pc[i][2], 19'h00000, 4'h9}, 24);
      hm.send({8'h00, pc[i][1], 19'h00000, 4'h3}, 24);
      chip_enable = pc[i][3];
      repeat (4) @(negedge clk_sys);
      chk({23'h000000, main_powered_down}, {23'h000000, pc[i][0]});
    end
    chip_enable = 1'b1;
  endtask
  // Reset for six cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    chip_enable = 1'b1;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_regs();
    t_range();
    t_refuse();
    t_quick();
    t_power();
    tally_and_finish();
  end
endmodule
bind ssrl_top ssrl_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .latch_strobe(latch_strobe), .chip_enable(chip_enable),
  .main_divider_value(main_divider_value), .divider_total(divider_total),
  .divider_in_range(divider_in_range), .prescaler_select(prescaler_select),
  .reference_divider(reference_divider), .aux_divider(aux_divider),
  .main_power_down(main_power_down), .auto_power_up(auto_power_up),
  .main_powered_down(main_powered_down), .counters_reset(counters_reset));
